// *** design/aisr_regs.sv ***
module aisr_regs
	import aisr_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [aisr_pkg::AISR_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_run_done,
	output logic [31:0] o_rdata,
	output logic o_restart,
	output logic o_run_launch
);
	import aisr_pkg::*;

	logic restart;
	logic start;
	logic busy;
	logic ready;
	logic [31:0] fault_code;
	logic fault_flag;
	aisr_state_e state;
	aisr_state_e next_state;
	logic next_restart;
	logic next_start;
	logic next_busy;
	logic next_ready;
	logic next_launch;
	logic [31:0] next_rdata;

	////////////////////////////////////////////////////////////////
	// Address decode.
	wire sel_ctrl = (i_addr == AISR_OFF_CTRL);
	wire sel_fault = (i_addr == AISR_OFF_FAULT);
	wire wr_ctrl = i_wr && sel_ctrl;
	wire wr_fault = i_wr && sel_fault;
	wire host_restart = wr_ctrl && i_wdata[AISR_BIT_RESTART];
	wire ctrl_live = wr_ctrl && !restart && !i_wdata[AISR_BIT_RESTART];
	wire wr_start = ctrl_live && i_wdata[AISR_BIT_START];
	wire wr_ack = ctrl_live && i_wdata[AISR_BIT_READY];

	////////////////////////////////////////////////////////////////
	// Error detection.
	// ack while clear
	wire err_ack = wr_ack && !ready;
	wire err_start = wr_start && start;
	wire err_any = err_ack || err_start;
	wire [31:0] err_code = err_ack ? AISR_CODE_READY_NOT_SET : AISR_CODE_START_NOT_CLEAR;
	wire soft_rst = host_restart || err_any;
	wire ack_ok = wr_ack && ready;

	////////////////////////////////////////////////////////////////
	// Run sequencing.
	// start to busy
	wire launch = start && !restart && (state == AISR_IDLE);
	wire finish_ok = !ready || ack_ok;

	always_comb begin
		next_state = state;
		next_launch = 1'b0;
		case (state)
			AISR_IDLE: begin
				if (launch) begin
					next_state = AISR_RUN;
					next_launch = 1'b1;
				end
			end
			AISR_RUN: begin
				if (i_run_done) begin
					next_state = finish_ok ? AISR_IDLE : AISR_HOLD;
				end
			end
			AISR_HOLD: begin
				if (finish_ok) begin
					next_state = AISR_IDLE;
				end
			end
			default: begin
				next_state = AISR_IDLE;
			end
		endcase
		if (soft_rst) begin
			next_state = AISR_IDLE;
			next_launch = 1'b0;
		end
	end

	wire finishing = finish_ok && ((state == AISR_RUN && i_run_done) || state == AISR_HOLD);

	always_comb begin
		next_restart = restart;
		next_start = start;
		next_busy = busy;
		next_ready = ready;
		if (wr_start) begin
			next_start = 1'b1;
		end
		if (launch) begin
			next_start = 1'b0;
			next_busy = 1'b1;
		end
		if (ack_ok) begin
			next_ready = 1'b0;
		end
		if (finishing) begin
			next_busy = 1'b0;
			next_ready = 1'b1;
		end
		if (wr_ctrl) begin
			next_restart = i_wdata[AISR_BIT_RESTART];
		end
		if (soft_rst) begin
			next_start = 1'b0;
			next_busy = 1'b0;
			next_ready = 1'b0;
		end
		if (err_any) begin
			next_restart = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read mux.
	// upper bits zero
	wire [31:0] ctrl_word = {27'h0000000, fault_flag, ready, busy, start, restart};

	always_comb begin
		if (sel_ctrl) begin
			next_rdata = ctrl_word;
		end else if (sel_fault) begin
			next_rdata = fault_code;
		end else begin
			next_rdata = AISR_UNMAPPED_READ;
		end
		if (!i_rd) begin
			next_rdata = o_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Fault register.
	// error sets fault
	aisr_fault_unit i_aisr_fault_unit (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_host_restart(host_restart),
		.i_fault_wr(wr_fault),
		.i_err_valid(err_any),
		.i_err_code(err_code),
		.o_fault_code(fault_code),
		.o_fault_flag(fault_flag)
	);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state <= AISR_IDLE;
			restart <= AISR_RESTART_RST;
			start <= 1'b0;
			busy <= 1'b0;
			ready <= 1'b0;
			o_rdata <= AISR_UNMAPPED_READ;
			o_run_launch <= 1'b0;
			o_restart <= AISR_RESTART_RST;
		end else begin
			state <= next_state;
			restart <= next_restart;
			start <= next_start;
			busy <= next_busy;
			ready <= next_ready;
			o_rdata <= next_rdata;
			o_run_launch <= next_launch;
			o_restart <= next_restart || err_any;
		end
	end
endmodule

// *** pkg/aisr_pkg.sv ***
package aisr_pkg;
	localparam int AISR_ADDR_W = 8;
	localparam logic [7:0] AISR_OFF_CTRL = 8'h00;
	localparam logic [7:0] AISR_OFF_FAULT = 8'h04;
	localparam int AISR_BIT_RESTART = 0;
	localparam int AISR_BIT_START = 1;
	localparam int AISR_BIT_BUSY = 2;
	localparam int AISR_BIT_READY = 3;
	localparam int AISR_BIT_FAULT = 4;
	localparam logic AISR_RESTART_RST = 1'b1;
	localparam logic [31:0] AISR_FAULT_RST = 32'h0000_0000;
	localparam logic [31:0] AISR_CODE_READY_NOT_SET = 32'h0000_0004;
	localparam logic [31:0] AISR_CODE_START_NOT_CLEAR = 32'h0000_0003;
	localparam logic [31:0] AISR_UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic [1:0] {
		AISR_IDLE,
		AISR_RUN,
		AISR_HOLD
	} aisr_state_e;
endpackage

// *** design/aisr_fault_unit.sv ***
module aisr_fault_unit
	import aisr_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_host_restart,
	input wire logic i_fault_wr,
	input wire logic i_err_valid,
	input wire logic [31:0] i_err_code,
	output logic [31:0] o_fault_code,
	output logic o_fault_flag
);
	import aisr_pkg::*;

	logic [31:0] next_fault_code;
	logic next_fault_flag;

	////////////////////////////////////////////////////////////////
	// Fault capture: a new error wins over a clearing write.
	// host restart clears
	assign next_fault_code = i_err_valid ? i_err_code :
		(i_fault_wr || i_host_restart) ? AISR_FAULT_RST : o_fault_code;
	assign next_fault_flag = i_err_valid ? 1'b1 :
		(i_fault_wr || i_host_restart) ? 1'b0 : o_fault_flag;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_fault_code <= AISR_FAULT_RST;
			o_fault_flag <= 1'b0;
		end else begin
			o_fault_code <= next_fault_code;
			o_fault_flag <= next_fault_flag;
		end
	end
endmodule

// *** verification/aisr_dp_model.sv ***
module aisr_dp_model #(parameter int DLY = 5) (
	input wire logic i_core_clk,
	input wire logic i_launch,
	input wire logic i_restart,
	output logic o_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial o_done = 1'b0;
	always @(posedge i_core_clk) begin
		o_done <= cnt == 1 && !i_restart;
		if (i_restart)
			cnt <= 0;
		else if (i_launch)
			cnt <= DLY;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule

// *** verification/aisr_regs_chk.sv ***
module aisr_regs_chk
	import aisr_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [aisr_pkg::AISR_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [31:0] o_rdata,
	input wire logic o_restart,
	input wire logic o_run_launch
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic cw = i_wr && i_addr == AISR_OFF_CTRL;
	wire logic fw = i_wr && i_addr == AISR_OFF_FAULT;
	wire logic fr = i_rd && i_addr == AISR_OFF_FAULT;
	wire logic ur = i_rd && i_addr != AISR_OFF_CTRL && !fr;
	launch_pulse_a: assert property (o_run_launch |=> !o_run_launch)
		else $error("launch long");
	launch_cause_a: assert property ($rose(o_run_launch)
		|-> $past(cw, 2) && $past(i_wdata[1], 2)) else $error("launch cause");
	rsvd_zero_a: assert property (i_rd && i_addr == AISR_OFF_CTRL
		|=> o_rdata[31:5] == 27'h0) else $error("rsvd bits");
	fault_clear_a: assert property (fw ##1 !i_wr ##1 fr
		|=> o_rdata == 32'h0) else $error("fault kept");
	host_restart_a: assert property (cw && i_wdata[0] |=> o_restart)
		else $error("no restart");
	restart_quiet_a: assert property (o_restart [*2] |-> !o_run_launch)
		else $error("launch in restart");
	unmapped_zero_a: assert property (ur |=> o_rdata == AISR_UNMAPPED_READ)
		else $error("unmapped");
	rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
		else $error("rdata moved");
	cover property (o_run_launch);
	cover property ($fell(o_restart));
	cover property (fw);
endmodule
bind aisr_regs aisr_regs_chk i_aisr_regs_chk (.i_core_clk, .i_rst_n, .i_wr, .i_rd,
	.i_addr, .i_wdata, .o_rdata, .o_restart, .o_run_launch);

// *** verification/tb_accel_invocation_status_regs.sv ***
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_accel_invocation_status_regs;
	import aisr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, rv = 0, i_run_done;
	logic o_restart, o_run_launch;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata, ex, r = 32'h278d;
	logic [31:0] q[$];
	int fails = 0, check_count = 0;
	always #4 i_core_clk = ~i_core_clk;
	aisr_regs i_aisr_regs (.i_core_clk, .i_rst_n, .i_wr, .i_rd, .i_addr, .i_wdata,
		.i_run_done, .o_rdata, .o_restart, .o_run_launch);
	aisr_dp_model #(.DLY(5)) i_aisr_dp_model (.i_core_clk, .i_launch(o_run_launch),
		.i_restart(o_restart), .o_done(i_run_done));
	function logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		q.push_back(e);
		@(posedge i_core_clk);
		i_rd <= 1'b0;
	endtask
	always @(posedge i_core_clk) begin
		if (rv) begin
			ex = q.pop_front();
			`CHK(o_rdata, ex)
		end
		rv <= i_rd;
	end
	task finish_test();
		$display("fails=%0d check_count=%0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rd(8'h00, 32'h1);
		rd(8'h04, AISR_FAULT_RST);
		wr(8'h00, 32'h0);
		r = nx(r);
		wr(8'h00, r & 32'hffff_ffe0);
		rd(8'h00, 32'h0);
		rd(8'h08, AISR_UNMAPPED_READ);
		wr(8'h00, 32'h2);
		rd(8'h00, 32'h4);
		repeat (8) @(posedge i_core_clk);
		rd(8'h00, 32'h8);
		wr(8'h00, 32'h8);
		rd(8'h00, 32'h0);
		wr(8'h00, 32'h2);
		repeat (8) @(posedge i_core_clk);
		wr(8'h00, 32'h2);
		repeat (8) @(posedge i_core_clk);
		rd(8'h00, 32'hc);
		wr(8'h00, 32'h8);
		rd(8'h00, 32'h8);
		wr(8'h00, 32'h8);
		repeat (8) @(posedge i_core_clk);
		rd(8'h00, 32'h0);
		wr(8'h00, 32'h2);
		wr(8'h00, 32'h8);
		repeat (8) @(posedge i_core_clk);
		rd(8'h04, AISR_CODE_READY_NOT_SET);
		rd(8'h00, 32'h10);
		r = nx(r);
		wr(8'h04, r);
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h0);
		wr(8'h00, 32'h8);
		wr(8'h00, 32'h1);
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h1);
		finish_test();
	end
	initial begin
		repeat (3000) @(posedge i_core_clk);
		fails++;
		finish_test();
	end
endmodule
